// file: sim/lgpm_led_gpio_pin_mux_tb_top.sv
`timescale 1ns/1ps
module lgpm_led_gpio_pin_mux_tb_top
    import lgpm_pkg::*;
;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic ack;
    logic err;
    // status per port and function: link, activity, speed, duplex
    logic [3:0] st [2][4] = '{'{4'h1, 4'h2, 4'h4, 4'h8}, '{4'h3, 4'h5, 4'hA, 4'hC}};
    logic [7:0] brd_val = 8'h00;
    logic [7:0] brd_oe = 8'h00;
    logic [7:0] pad_lvl, p_out, p_oe, p_pu, p_ib;
    logic [3:0] led1_n, led2_n;
    logic [31:0] q;
    logic e;
    int n_errors = 0;
    int comparisons = 0;

    lgpm_led_gpio_pin_mux #(.NPINS(8)) i_lgpm_led_gpio_pin_mux (.mclk(mclk), .arst_n(arst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .port1_link(st[0][0]), .port1_act(st[0][1]),
        .port1_speed(st[0][2]), .port1_duplex(st[0][3]), .port2_link(st[1][0]), .port2_act(st[1][1]),
        .port2_speed(st[1][2]), .port2_duplex(st[1][3]), .pad_in(pad_lvl), .pad_out(p_out), .pad_oe(p_oe),
        .pad_pullup_en(p_pu), .pad_inbuf_en(p_ib), .port1_status_led_n(led1_n), .port2_status_led_n(led2_n));
    lgpm_pad_board i_lgpm_pad_board (.mclk(mclk), .pad_out(p_out), .pad_oe(p_oe), .pad_pullup_en(p_pu),
        .brd_val(brd_val), .brd_oe(brd_oe), .pad_lvl(pad_lvl));

    // free-running system clock
    always #12.5 mclk = ~mclk;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // classic cycle; request held until ack or err is sampled high at a rising edge, data taken there
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        @(posedge mclk);
        while (ack !== 1'b1 && err !== 1'b1 && n < 20)
        begin
            @(posedge mclk);
            n++;
        end
        if (n == 20)
            n_errors++;
        q = rdat;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h00000000, 4'hF);
        chk("read data", exp, q);
    endtask

    // pads follow the registers one cycle after the ack
    task automatic pads(input logic [7:0] o, input logic [7:0] m, input logic [7:0] oe, input logic [7:0] pu);
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk("pad_out", {24'h000000, o}, {24'h000000, p_out & m});
        chk("pad_oe", {24'h000000, oe}, {24'h000000, p_oe});
        chk("pad_pullup_en", {24'h000000, pu}, {24'h000000, p_pu});
    endtask

    task automatic t_reset;
        pads(8'h00, 8'hFF, 8'h00, 8'hFF);
        chk("pad_inbuf_en", 32'h000000FF, {24'h000000, p_ib});
        chk("led_n", 32'h000000FF, {24'h000000, led2_n, led1_n});
        rd(8'h00, 32'h00000000);
        rd(8'h04, 32'h00000000);
        rd(8'h08, 32'h00000000);
    endtask

    task automatic t_led;
        logic [7:0] s8, role;
        for (int fn = 0; fn < 4; fn++)
        begin
            for (int r = 0; r < 2; r++)
            begin
                role = r ? 8'h0F : 8'hF0;
                s8 = {st[1][fn], st[0][fn]};
                wb(1'b1, 8'h00, {22'h000000, fn[1:0], role}, 4'hF);
                pads(8'h00, role, s8 & role, ~role);
                chk("pad_inbuf_en", {24'h000000, ~role}, {24'h000000, p_ib});
                chk("led_n", {24'h000000, ~(s8 & role)}, {24'h000000, led2_n, led1_n});
            end
        end
    endtask

    task automatic t_gpio_out;
        wb(1'b1, 8'h00, 32'h00000000, 4'hF);
        wb(1'b1, 8'h08, 32'h0000FFA5, 4'hF);
        wb(1'b1, 8'h04, 32'h00000000, 4'hF);
        pads(8'hA5, 8'hFF, 8'hFF, 8'hFF);
        chk("pad_inbuf_en", 32'h00000000, {24'h000000, p_ib});
        wb(1'b1, 8'h04, 32'h000000FF, 4'hF);
        pads(8'h00, 8'hFF, 8'h5A, 8'hFF);
        rd(8'h04, 32'h000000FF);
    endtask

    task automatic t_gpio_in;
        wb(1'b1, 8'h08, 32'h00000000, 4'hF);
        @(posedge mclk);
        brd_oe <= 8'hFF;
        brd_val <= 8'h3C;
        repeat (8) @(posedge mclk);
        rd(8'h0C, 32'h0000003C);
        chk("pad_inbuf_en", 32'h000000FF, {24'h000000, p_ib});
        brd_oe <= 8'h00;
        repeat (8) @(posedge mclk);
        rd(8'h0C, 32'h000000FF);
    endtask

    // byte lanes and an unmapped address
    task automatic t_bus;
        wb(1'b1, 8'h08, 32'h0000FF5A, 4'h1);
        rd(8'h08, 32'h0000005A);
        wb(1'b1, 8'h10, 32'h000003FF, 4'hF);
        chk("err", 32'h00000001, {31'h00000000, e});
        rd(8'h00, 32'h00000000);
    endtask

    task automatic close_out;
        $display("mismatches %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        t_reset;
        t_led;
        t_gpio_out;
        t_gpio_in;
        t_bus;
        close_out;
    end

    // the whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        close_out;
    end
endmodule

// file: sim/lgpm_pad_board.sv
`timescale 1ns/1ps
// board side of the shared pins: status leds or general board signals
module lgpm_pad_board
    import lgpm_pkg::*;
(
    // clock
    input wire logic mclk,
    // pad drive from the device
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_pullup_en,
    // board drivers, set by the scenario
    input wire logic [7:0] brd_val,
    input wire logic [7:0] brd_oe,
    // resolved pin level
    output logic [7:0] pad_lvl
);
    logic [7:0] last_ff;
    // device drive wins, then board drive, then pull-up; a floating pin toggles so no stale value passes
    assign pad_lvl = (pad_oe & pad_out) | (~pad_oe & brd_oe & brd_val) | (~pad_oe & ~brd_oe & pad_pullup_en)
                   | (~pad_oe & ~brd_oe & ~pad_pullup_en & ~last_ff);
    // last level, only used while floating
    always_ff @(posedge mclk)
        last_ff <= pad_lvl;
endmodule

// file: src/lgpm_cfg.svh
`ifndef LGPM_CFG_SVH
`define LGPM_CFG_SVH

// register byte offsets on the wishbone bus
`define LGPM_LED_CONFIG_REG_OFS 8'h00
`define LGPM_GPIO_CFG_OFS 8'h04
`define LGPM_GPIO_DDR_OFS 8'h08
`define LGPM_PIN_STAT_OFS 8'h0C

// led_config_reg fields: role bits per pin, function field
`define LGPM_LED_EN_LSB 0
`define LGPM_LED_EN_MSB 7
`define LGPM_LED_FN_LSB 8
`define LGPM_LED_FN_MSB 9

// gpio configuration: low byte push-pull(0)/open-drain(1)
`define LGPM_GPIO_OD_LSB 0
`define LGPM_GPIO_OD_MSB 7

// data and direction: low byte data, bits 15:8 direction (1 = output)
`define LGPM_DDR_DAT_LSB 0
`define LGPM_DDR_DAT_MSB 7
`define LGPM_DDR_DIR_LSB 8
`define LGPM_DDR_DIR_MSB 15

// reset values
`define LGPM_LED_CONFIG_REG_RST 32'h00000000
`define LGPM_GPIO_CFG_RST 32'h00000000
`define LGPM_GPIO_DDR_RST 32'h00000000

`endif

// file: src/lgpm_led_gpio_pin_mux.sv
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "lgpm_cfg.svh"
// Summary of operation
// - eight shared pins: low four carry port one leds, high four port two leds
// - led_config_reg bit per pin picks led or gpio role
// - led role: active-low open-drain drive, pull-up and input buffer off
// - led_config_reg bits 9:8 choose which status the led pins show
// - gpio role: push-pull, open-drain or schmitt input set by two gpio registers
// - pull-up is on for every gpio-role pin regardless of direction
// - gpio input buffer off while output, on while input
module lgpm_led_gpio_pin_mux
    import lgpm_pkg::*;
#(
    parameter int NPINS = 8
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // switch port status, one bit per led slot [3:0] for each of link, activity, speed and duplex
    input wire logic [3:0] port1_link,
    input wire logic [3:0] port1_act,
    input wire logic [3:0] port1_speed,
    input wire logic [3:0] port1_duplex,
    input wire logic [3:0] port2_link,
    input wire logic [3:0] port2_act,
    input wire logic [3:0] port2_speed,
    input wire logic [3:0] port2_duplex,
    // pad control
    input wire logic [NPINS-1:0] pad_in,
    output logic [NPINS-1:0] pad_out,
    output logic [NPINS-1:0] pad_oe,
    output logic [NPINS-1:0] pad_pullup_en,
    output logic [NPINS-1:0] pad_inbuf_en,
    // led view, active low, open-drain level seen on pins
    output logic [3:0] port1_status_led_n,
    output logic [3:0] port2_status_led_n
);

    // registers
    logic [31:0] led_config_reg_ff;
    logic [31:0] gpio_cfg_ff;
    logic [31:0] gpio_ddr_ff;
    logic wb_ack_ff;
    logic wb_err_ff;
    logic [31:0] wb_dat_ff;
    logic [NPINS-1:0] pad_out_ff;
    logic [NPINS-1:0] pad_oe_ff;
    logic [NPINS-1:0] pad_pu_ff;
    logic [NPINS-1:0] pad_ib_ff;
    logic [3:0] p1_led_ff;
    logic [3:0] p2_led_ff;
    logic [NPINS-1:0] pin_sync;

    // pad inputs are asynchronous to mclk
    lgpm_pin_sync #(
        .WIDTH(NPINS)
    ) u_sync (
        .mclk(mclk),
        .arst_n(arst_n),
        .raw_in(pad_in),
        .clean_out(pin_sync)
    );

    // bus decode; one request answered per access, ack drops the cycle after
    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_ff && !wb_err_ff;
    wire hit_led = (wb_adr_i == `LGPM_LED_CONFIG_REG_OFS);
    wire hit_gcfg = (wb_adr_i == `LGPM_GPIO_CFG_OFS);
    wire hit_ddr = (wb_adr_i == `LGPM_GPIO_DDR_OFS);
    wire hit_stat = (wb_adr_i == `LGPM_PIN_STAT_OFS);
    wire hit_any = hit_led || hit_gcfg || hit_ddr || hit_stat;
    wire wr_ok = bus_req && wb_we_i && hit_any;

    // byte-lane merge for writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // only implemented bits are kept; others read zero
    wire [31:0] led_mask = 32'h000003FF;
    wire [31:0] gcfg_mask = 32'h000000FF;
    wire [31:0] ddr_mask = 32'h0000FFFF;
    wire [31:0] nxt_led_config_reg = lane_merge(led_config_reg_ff, wb_dat_i, wb_sel_i) & led_mask;
    wire [31:0] nxt_gpio_cfg = lane_merge(gpio_cfg_ff, wb_dat_i, wb_sel_i) & gcfg_mask;
    wire [31:0] nxt_gpio_ddr = lane_merge(gpio_ddr_ff, wb_dat_i, wb_sel_i) & ddr_mask;

    // status register shows synchronised pin levels
    wire [31:0] stat_word = {{(32-NPINS){1'b0}}, pin_sync};
    wire [31:0] nxt_rd = hit_led ? led_config_reg_ff :
                         hit_gcfg ? gpio_cfg_ff :
                         hit_ddr ? gpio_ddr_ff :
                         hit_stat ? stat_word : 32'h00000000;

    // register file writes
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            led_config_reg_ff <= `LGPM_LED_CONFIG_REG_RST;
            gpio_cfg_ff <= `LGPM_GPIO_CFG_RST;
            gpio_ddr_ff <= `LGPM_GPIO_DDR_RST;
        end
        else if (wr_ok)
        begin
            if (hit_led)
                led_config_reg_ff <= nxt_led_config_reg;
            if (hit_gcfg)
                gpio_cfg_ff <= nxt_gpio_cfg;
            if (hit_ddr)
                gpio_ddr_ff <= nxt_gpio_ddr;
        end
    end

    // bus answer: ack or err one cycle after the request; unmapped gives err
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wb_ack_ff <= 1'b0;
            wb_err_ff <= 1'b0;
            wb_dat_ff <= 32'h00000000;
        end
        else
        begin
            wb_ack_ff <= bus_req && hit_any;
            wb_err_ff <= bus_req && !hit_any;
            wb_dat_ff <= (bus_req && !wb_we_i) ? nxt_rd : 32'h00000000;
        end
    end

    // led function select and active-low state
    wire [1:0] fn_bits = led_config_reg_ff[`LGPM_LED_FN_MSB:`LGPM_LED_FN_LSB];
    lgpm_led_fn_t led_fn;
    assign led_fn = lgpm_led_fn_t'(fn_bits);
    wire [3:0] p1_sel = (led_fn == LGPM_FN_LINK) ? port1_link :
                        (led_fn == LGPM_FN_ACT) ? port1_act :
                        (led_fn == LGPM_FN_SPEED) ? port1_speed : port1_duplex;
    wire [3:0] p2_sel = (led_fn == LGPM_FN_LINK) ? port2_link :
                        (led_fn == LGPM_FN_ACT) ? port2_act :
                        (led_fn == LGPM_FN_SPEED) ? port2_speed : port2_duplex;
    wire [NPINS-1:0] led_on = {p2_sel, p1_sel};

    // per-pin pad control
    logic [NPINS-1:0] nxt_pad_out;
    logic [NPINS-1:0] nxt_pad_oe;
    logic [NPINS-1:0] nxt_pad_pu;
    logic [NPINS-1:0] nxt_pad_ib;
    genvar gp;
    generate
        for (gp = 0; gp < NPINS; gp++)
        begin : g_pin
            wire is_led = led_config_reg_ff[`LGPM_LED_EN_LSB + gp];
            wire g_dir = gpio_ddr_ff[`LGPM_DDR_DIR_LSB + gp];
            wire g_dat = gpio_ddr_ff[`LGPM_DDR_DAT_LSB + gp];
            wire g_od = gpio_cfg_ff[`LGPM_GPIO_OD_LSB + gp];
            // led: drive low when lit, release otherwise; output value always 0
            assign nxt_pad_out[gp] = is_led ? 1'b0 : (g_od ? 1'b0 : g_dat);
            assign nxt_pad_oe[gp] = is_led ? led_on[gp] :
                                    (g_dir ? (g_od ? !g_dat : 1'b1) : 1'b0);
            assign nxt_pad_pu[gp] = !is_led;
            assign nxt_pad_ib[gp] = !is_led && !g_dir;
        end
    endgenerate

    // wired level on led pins as seen outside (low while sinking)
    wire [NPINS-1:0] led_n_lvl = ~(led_on & led_config_reg_ff[`LGPM_LED_EN_MSB:`LGPM_LED_EN_LSB]);

    // all pad outputs registered so the pins never glitch on decode changes
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pad_out_ff <= '0;
            pad_oe_ff <= '0;
            pad_pu_ff <= '1;
            pad_ib_ff <= '1;
            p1_led_ff <= 4'hF;
            p2_led_ff <= 4'hF;
        end
        else
        begin
            pad_out_ff <= nxt_pad_out;
            pad_oe_ff <= nxt_pad_oe;
            pad_pu_ff <= nxt_pad_pu;
            pad_ib_ff <= nxt_pad_ib;
            p1_led_ff <= led_n_lvl[3:0];
            p2_led_ff <= led_n_lvl[7:4];
        end
    end

    assign pad_out = pad_out_ff;
    assign pad_oe = pad_oe_ff;
    assign pad_pullup_en = pad_pu_ff;
    assign pad_inbuf_en = pad_ib_ff;
    assign port1_status_led_n = p1_led_ff;
    assign port2_status_led_n = p2_led_ff;
    assign wb_ack_o = wb_ack_ff;
    assign wb_err_o = wb_err_ff;
    assign wb_dat_o = wb_dat_ff;

    // led-role pin never drives high and has pull-up and input buffer off
    property p_led_od;
        @(posedge mclk) disable iff (!arst_n)
        $past(led_config_reg_ff[0]) |-> (!pad_out[0] && !pad_pullup_en[0] && !pad_inbuf_en[0]);
    endproperty
    a_led_od: assert property (p_led_od) else $error("led pin not open-drain");

    // lit led sinks the pin one cycle after status rises
    property p_led_on;
        @(posedge mclk) disable iff (!arst_n)
        (led_config_reg_ff[4] && led_fn == LGPM_FN_LINK && port2_link[0]) ##1 led_config_reg_ff[4]
        |-> pad_oe[4] && !port2_status_led_n[0];
    endproperty
    a_led_on: assert property (p_led_on) else $error("port2 led not lit");

    // function field steers the led source: activity chosen, so a live link alone leaves pin zero dark
    property p_fn_sel;
        @(posedge mclk) disable iff (!arst_n)
        (led_config_reg_ff[0] && fn_bits == 2'h1 && !port1_act[0] && port1_link[0])
        |=> !pad_oe[0];
    endproperty
    a_fn_sel: assert property (p_fn_sel) else $error("led function ignored");

    // gpio pin keeps pull-up on
    property p_gpio_pu;
        @(posedge mclk) disable iff (!arst_n)
        !led_config_reg_ff[2] |=> pad_pullup_en[2];
    endproperty
    a_gpio_pu: assert property (p_gpio_pu) else $error("gpio pull-up off");

    // output direction disables input buffer
    property p_gpio_ib;
        @(posedge mclk) disable iff (!arst_n)
        (!led_config_reg_ff[3] && gpio_ddr_ff[11]) |=> !pad_inbuf_en[3];
    endproperty
    a_gpio_ib: assert property (p_gpio_ib) else $error("input buffer on while output");

    // push-pull output drives both levels
    property p_gpio_pp;
        @(posedge mclk) disable iff (!arst_n)
        (!led_config_reg_ff[5] && gpio_ddr_ff[13] && !gpio_cfg_ff[5])
        |=> pad_oe[5] && (pad_out[5] == $past(gpio_ddr_ff[5]));
    endproperty
    a_gpio_pp: assert property (p_gpio_pp) else $error("push-pull drive wrong");

    // open-drain output never drives high
    property p_gpio_od;
        @(posedge mclk) disable iff (!arst_n)
        (!led_config_reg_ff[6] && gpio_cfg_ff[6]) |=> !pad_out[6];
    endproperty
    a_gpio_od: assert property (p_gpio_od) else $error("open-drain drove high");

    // role write lands and reads back
    property p_role_wr;
        @(posedge mclk) disable iff (!arst_n)
        (wr_ok && hit_led && wb_sel_i[0]) |=> led_config_reg_ff[7:0] == $past(wb_dat_i[7:0]);
    endproperty
    a_role_wr: assert property (p_role_wr) else $error("role write lost");

    // port two leds live on the high pins
    property p_port_map;
        @(posedge mclk) disable iff (!arst_n)
        (led_config_reg_ff[7] && fn_bits == 2'h3) ##1 led_config_reg_ff[7]
        |-> pad_oe[7] == $past(port2_duplex[3]);
    endproperty
    a_port_map: assert property (p_port_map) else $error("port led mapping wrong");

    // led-role pin on the high side keeps pull-up and input buffer off as well
    property p_led_pad7;
        @(posedge mclk) disable iff (!arst_n)
        led_config_reg_ff[7] |=> (!pad_pullup_en[7] && !pad_inbuf_en[7] && !pad_out[7]);
    endproperty
    a_led_pad7: assert property (p_led_pad7) else $error("high led pin pad wrong");

    // input direction releases the pin and keeps the schmitt input buffer on
    property p_gpio_in;
        @(posedge mclk) disable iff (!arst_n)
        (!led_config_reg_ff[0] && !gpio_ddr_ff[8]) |=> (!pad_oe[0] && pad_inbuf_en[0]);
    endproperty
    a_gpio_in: assert property (p_gpio_in) else $error("gpio input pin driven");

    // lit status pulls the active-low led view down one cycle later
    property p_led_inv;
        @(posedge mclk) disable iff (!arst_n)
        (led_config_reg_ff[2] && fn_bits == 2'h2) |=> port1_status_led_n[2] == !$past(port1_speed[2]);
    endproperty
    a_led_inv: assert property (p_led_inv) else $error("led view not inverted");

endmodule

// file: src/lgpm_pin_sync.sv
`timescale 1ns/1ps
// three-stage input synchroniser per pin; change accepted when stages two and three agree
module lgpm_pin_sync
    import lgpm_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // raw and filtered levels
    input wire logic [WIDTH-1:0] raw_in,
    output logic [WIDTH-1:0] clean_out
);

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            logic s1_ff;
            logic s2_ff;
            logic s3_ff;
            logic hold_ff;
            wire agree = (s2_ff == s3_ff);
            wire nxt_hold = agree ? s3_ff : hold_ff;
            // first stage feeds only the second
            always_ff @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    s1_ff <= 1'b0;
                    s2_ff <= 1'b0;
                    s3_ff <= 1'b0;
                    hold_ff <= 1'b0;
                end
                else
                begin
                    s1_ff <= raw_in[gi];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    hold_ff <= nxt_hold;
                end
            end
            assign clean_out[gi] = hold_ff;
        end
    endgenerate

endmodule

// file: src/lgpm_pkg.sv
package lgpm_pkg;
    // led function select (two bit field)
    typedef enum logic [1:0] {
        LGPM_FN_LINK,
        LGPM_FN_ACT,
        LGPM_FN_SPEED,
        LGPM_FN_DUPLEX
    } lgpm_led_fn_t;
    // per-pin role
    typedef enum logic {
        LGPM_ROLE_GPIO,
        LGPM_ROLE_LED
    } lgpm_role_t;
endpackage
